// ---- core/monitor_config_register_bank.v ----
`timescale 1ns/1ps
`include "monitor_consts.vh"
module monitor_config_register_bank #(
   parameter PULSE_CYCLES = `PULSE_CYCLES,
   parameter PW           = 21
) (
   input  wire       clk_sys,          // 200 MHz system clock.
   input  wire       rst,              // Asynchronous power-on reset.
   input  wire       scl_in,           // Serial clock pin.
   input  wire       sda_in,           // Serial data pin, input side.
   output reg        sda_oe_q,         // Serial data driven low when high.
   input  wire [7:0] event_in_one,     // Events from scanning, group one.
   input  wire [7:0] event_in_two,     // Events from scanning, group two.
   input  wire       ot_alarm,         // Overtemperature from scanning.
   output reg        monitor_run_q,    // Scanning and comparison allowed.
   output reg        alert_out_q,      // Alert pin level.
   output reg        alert_oe_q,       // Alert pin drive enable.
   output reg        reset_or_overtemp_pin_oe_q, // Drives pin low.
   output reg        intrusion_input_oe_q,       // Pulls intrusion line low.
   output reg        general_output_pin_oe_q,    // Drives general pin low.
   output reg  [7:0] ot_cfg_q          // Overtemperature configuration.
);
   localparam S_IDLE = 3'd0, S_ADDR = 3'd1, S_PTR = 3'd2, S_WDAT = 3'd3;
   localparam S_RDAT = 3'd4, S_ACK = 3'd5, S_RACK = 3'd6, S_SKIP = 3'd7;

   reg [1:0] scl_s_q, sda_s_q;
   reg       scl_p_q, sda_p_q;
   reg [7:0] ptr_q, cfg_q, stat1_q, stat2_q, mask1_q, mask2_q, fdp_q;
   reg [2:0] st_q, nxt_q;
   reg [3:0] bit_q;
   reg [7:0] sh_q;
   wire      scl = scl_s_q[1];
   wire      sda = sda_s_q[1];
   wire      scl_rise = scl & ~scl_p_q;
   wire      scl_fall = ~scl & scl_p_q;
   wire      start_c = scl & scl_p_q & sda_p_q & ~sda;
   wire      stop_c  = scl & scl_p_q & ~sda_p_q & sda;
   wire      rst_busy, ci_busy;
   reg       rst_go_q, ci_go_q;

   function [7:0] read_mux;
      input [7:0] a;
      begin
         if (a == `REG_MAIN_CFG) read_mux = cfg_q;
         else if (a == `REG_EVT_STAT_ONE) read_mux = stat1_q;
         else if (a == `REG_EVT_STAT_TWO) read_mux = stat2_q;
         else if (a == `REG_EVT_MASK_ONE) read_mux = mask1_q;
         else if (a == `REG_EVT_MASK_TWO) read_mux = mask2_q;
         else if (a == `REG_FAN_DIV_PIN) read_mux = fdp_q;
         else if (a == `REG_OT_CFG) read_mux = ot_cfg_q;
         else read_mux = 8'h00;
      end
   endfunction

   // Two flops on each pin before any logic reads it.
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         scl_s_q <= 2'b11;
         sda_s_q <= 2'b11;
         scl_p_q <= 1'b1;
         sda_p_q <= 1'b1;
      end else begin
         scl_s_q <= {scl_s_q[0], scl_in};
         sda_s_q <= {sda_s_q[0], sda_in};
         scl_p_q <= scl;
         sda_p_q <= sda;
      end
   end

   pulse_timer #(.CYCLES(PULSE_CYCLES), .W(PW)) u_rst_timer (
      .clk_sys (clk_sys),
      .rst     (rst),
      .start   (rst_go_q),
      .busy_q  (rst_busy)
   );
   pulse_timer #(.CYCLES(PULSE_CYCLES), .W(PW)) u_ci_timer (
      .clk_sys (clk_sys),
      .rst     (rst),
      .start   (ci_go_q),
      .busy_q  (ci_busy)
   );

   // Bus engine and register file share one process so each register
   // keeps a single driver.
   wire wr_byte = (st_q == S_WDAT) && scl_rise && (bit_q == 4'd7);
   wire [7:0] wdat = {sh_q[6:0], sda};
   wire rd_stat1 = (st_q == S_RDAT) && (bit_q == 4'd0) && scl_fall
                   && (ptr_q == `REG_EVT_STAT_ONE);
   wire rd_stat2 = (st_q == S_RDAT) && (bit_q == 4'd0) && scl_fall
                   && (ptr_q == `REG_EVT_STAT_TWO);

   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         st_q     <= S_IDLE;
         nxt_q    <= S_IDLE;
         bit_q    <= 4'd0;
         sh_q     <= 8'h00;
         sda_oe_q <= 1'b0;
         ptr_q    <= `RST_POINTER;
         cfg_q    <= `RST_MAIN_CFG;
         stat1_q  <= `RST_EVT_STAT;
         stat2_q  <= `RST_EVT_STAT;
         mask1_q  <= `RST_EVT_MASK;
         mask2_q  <= `RST_EVT_MASK;
         fdp_q    <= `RST_FAN_DIV_PIN;
         ot_cfg_q <= `RST_OT_CFG;
         rst_go_q <= 1'b0;
         ci_go_q  <= 1'b0;
      end else begin
         rst_go_q <= 1'b0;
         ci_go_q  <= 1'b0;
         // Status: read clears, but a new event in the same cycle wins.
         stat1_q <= (rd_stat1 ? 8'h00 : stat1_q) | event_in_one;
         stat2_q <= (rd_stat2 ? 8'h00 : stat2_q)
                    | (event_in_two & 8'h3f);
         if (start_c) begin
            st_q     <= S_ADDR;
            bit_q    <= 4'd0;
            sda_oe_q <= 1'b0;
         end else if (stop_c) begin
            st_q     <= S_IDLE;
            sda_oe_q <= 1'b0;
         end else begin
            case (st_q)
               S_ADDR, S_PTR, S_WDAT: begin
                  if (scl_rise) begin
                     sh_q  <= wdat;
                     bit_q <= bit_q + 4'd1;
                  end
                  if (scl_fall && bit_q == 4'd8) begin
                     bit_q <= 4'd0;
                     if (st_q == S_ADDR) begin
                        if (sh_q[7:1] == `DEV_ADDR) begin
                           sda_oe_q <= 1'b1;
                           st_q     <= S_ACK;
                           nxt_q    <= sh_q[0] ? S_RDAT : S_PTR;
                        end else begin
                           st_q <= S_SKIP;
                        end
                     end else begin
                        if (st_q == S_PTR) begin
                           ptr_q <= sh_q;
                        end
                        sda_oe_q <= 1'b1;
                        st_q     <= S_ACK;
                        nxt_q    <= S_WDAT;
                     end
                  end
               end
               S_ACK: begin
                  if (scl_fall) begin
                     st_q  <= nxt_q;
                     bit_q <= 4'd0;
                     if (nxt_q == S_RDAT) begin
                        sh_q     <= read_mux(ptr_q);
                        sda_oe_q <= ~read_mux(ptr_q) >> 7 != 8'h00;
                     end else begin
                        sda_oe_q <= 1'b0;
                     end
                  end
               end
               S_RDAT: begin
                  if (scl_fall) begin
                     if (bit_q == 4'd7) begin
                        sda_oe_q <= 1'b0;
                        st_q     <= S_RACK;
                     end else begin
                        sda_oe_q <= ~sh_q[6];
                        sh_q     <= {sh_q[6:0], 1'b0};
                        bit_q    <= bit_q + 4'd1;
                     end
                  end
               end
               S_RACK: begin
                  if (scl_rise) begin
                     st_q  <= sda ? S_SKIP : S_ACK;
                     nxt_q <= S_RDAT;
                  end
               end
               default: begin
                  sda_oe_q <= 1'b0;
               end
            endcase
         end
         // Register writes land on the pointed location.
         if (wr_byte) begin
            if (ptr_q == `REG_MAIN_CFG) begin
               if (wdat[`CFG_RESTORE]) begin
                  cfg_q    <= `RST_MAIN_CFG;
                  stat1_q  <= `RST_EVT_STAT;
                  stat2_q  <= `RST_EVT_STAT;
                  mask1_q  <= `RST_EVT_MASK;
                  mask2_q  <= `RST_EVT_MASK;
                  fdp_q    <= `RST_FAN_DIV_PIN;
                  ot_cfg_q <= `RST_OT_CFG;
               end else begin
                  cfg_q <= {1'b0, wdat[6:0]};
                  // Only honoured when the pin is in reset mode.
                  if (wdat[`CFG_RESET_PULSE] && fdp_q[`FDP_RST_EN]
                      && !fdp_q[`FDP_OT_EN]) begin
                     rst_go_q <= 1'b1;
                  end else begin
                     cfg_q[`CFG_RESET_PULSE] <= 1'b0;
                  end
                  ci_go_q <= wdat[`CFG_INTR_CLEAR];
               end
            end else if (ptr_q == `REG_EVT_MASK_ONE) begin
               mask1_q <= wdat;
            end else if (ptr_q == `REG_EVT_MASK_TWO) begin
               mask2_q <= wdat;
            end else if (ptr_q == `REG_FAN_DIV_PIN) begin
               fdp_q <= wdat;
            end else if (ptr_q == `REG_OT_CFG) begin
               ot_cfg_q <= wdat;
            end
         end else begin
            if (!rst_busy && !rst_go_q) begin
               cfg_q[`CFG_RESET_PULSE] <= 1'b0;
            end
            if (!ci_busy && !ci_go_q) begin
               cfg_q[`CFG_INTR_CLEAR] <= 1'b0;
            end
         end
      end
   end

   // Pin outputs, all registered.
   wire any_evt = |(stat1_q & ~mask1_q) | |(stat2_q & ~mask2_q);
   wire alert_act = cfg_q[`CFG_ALERT_EN] & any_evt
                    & ~cfg_q[`CFG_QUIET];
   wire ot_mode = !fdp_q[`FDP_RST_EN] && fdp_q[`FDP_OT_EN];

   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         monitor_run_q              <= 1'b0;
         alert_out_q                <= 1'b0;
         alert_oe_q                 <= 1'b0;
         reset_or_overtemp_pin_oe_q <= 1'b0;
         intrusion_input_oe_q       <= 1'b0;
         general_output_pin_oe_q    <= 1'b0;
      end else begin
         // Quieting overrides start; scanning resumes on its own.
         monitor_run_q <= cfg_q[`CFG_START] & ~cfg_q[`CFG_QUIET];
         // High polarity drives a one; low polarity only sinks.
         alert_out_q <= cfg_q[`CFG_ALERT_POL];
         alert_oe_q  <= alert_act;
         reset_or_overtemp_pin_oe_q <= ~cfg_q[`CFG_QUIET]
            & (rst_busy | (ot_mode & ot_alarm));
         intrusion_input_oe_q    <= ci_busy;
         general_output_pin_oe_q <= ~cfg_q[`CFG_GPO];
      end
   end
endmodule // monitor_config_register_bank

// ---- pkg/monitor_consts.vh ----
`ifndef MONITOR_CONSTS_VH
`define MONITOR_CONSTS_VH
// Register indices reached through the pointer.
`define REG_MAIN_CFG      8'h00
`define REG_EVT_STAT_ONE  8'h01
`define REG_EVT_STAT_TWO  8'h02
`define REG_EVT_MASK_ONE  8'h03
`define REG_EVT_MASK_TWO  8'h04
`define REG_FAN_DIV_PIN   8'h05
`define REG_OT_CFG        8'h06
// Power-on values.
`define RST_MAIN_CFG      8'h08
`define RST_EVT_STAT      8'h00
`define RST_EVT_MASK      8'h00
`define RST_FAN_DIV_PIN   8'h14
`define RST_OT_CFG        8'h01
`define RST_POINTER       8'h00
// Configuration bit positions.
`define CFG_START         0
`define CFG_ALERT_EN      1
`define CFG_ALERT_POL     2
`define CFG_QUIET         3
`define CFG_RESET_PULSE   4
`define CFG_INTR_CLEAR    5
`define CFG_GPO           6
`define CFG_RESTORE       7
// Fan divisor register pin-select bits.
`define FDP_RST_EN        7
`define FDP_OT_EN         6
// Timing.
`define PULSE_MS          10
`define CLK_MHZ           200
`define PULSE_CYCLES      (`PULSE_MS * 1000 * `CLK_MHZ)
// Serial bus device address (arbitrary value).
`define DEV_ADDR          7'h28
`endif

// ---- core/pulse_timer.v ----
`timescale 1ns/1ps
// Holds busy high for a fixed number of cycles after a start pulse.
module pulse_timer #(
   parameter CYCLES = 2000000,
   parameter W      = 21
) (
   input  wire clk_sys, // System clock.
   input  wire rst,     // Asynchronous reset, active high.
   input  wire start,   // Starts a run when idle.
   output reg  busy_q   // High while the run lasts.
);
   reg [W-1:0] cnt_q;

   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         cnt_q  <= {W{1'b0}};
         busy_q <= 1'b0;
      end else if (busy_q) begin
         if (cnt_q == CYCLES[W-1:0] - 1'b1) begin
            busy_q <= 1'b0;
            cnt_q  <= {W{1'b0}};
         end else begin
            cnt_q <= cnt_q + 1'b1;
         end
      end else if (start) begin
         busy_q <= 1'b1;
      end
   end
endmodule // pulse_timer

// ---- test/monitor_config_register_bank_asserts.sv ----
`timescale 1ns/1ps
module monitor_config_register_bank_asserts #(
   parameter PULSE_CYCLES = 20
) (
   input wire       clk_sys,                    // Clock.
   input wire       rst,                        // Reset.
   input wire       scl_in,                     // Serial clock.
   input wire       sda_oe_q,                   // Data pull.
   input wire       monitor_run_q,              // Scan allowed.
   input wire       alert_oe_q,                 // Alert drive.
   input wire       reset_or_overtemp_pin_oe_q, // Reset pull.
   input wire       intrusion_input_oe_q,       // Latch clear.
   input wire       general_output_pin_oe_q,    // Output pull.
   input wire [7:0] ot_cfg_q                    // Overtemp cfg.
);
   int hi_int_q;
   int hi_rst_q;
   // Run lengths of both pulses, so their exact width can be judged.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         hi_int_q <= 0;
         hi_rst_q <= 0;
      end else begin
         hi_int_q <= intrusion_input_oe_q ? hi_int_q + 1 : 0;
         hi_rst_q <= reset_or_overtemp_pin_oe_q ? hi_rst_q + 1 : 0;
      end
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   sequence s_int_go;
      $rose(intrusion_input_oe_q);
   endsequence
   sequence s_rst_go;
      $rose(reset_or_overtemp_pin_oe_q);
   endsequence
   a_reset_values: assert property ($fell(rst) |-> !monitor_run_q
      && !alert_oe_q && ot_cfg_q == 8'h01) else $error("bad reset state");
   a_sda_scl_low: assert property ($changed(sda_oe_q) |-> !scl_in)
      else $error("data moved while clock high");
   a_cfg_on_write: assert property ($changed(monitor_run_q)
      || $changed(general_output_pin_oe_q) |-> scl_in)
      else $error("config output moved outside a write");
   a_int_min_len: assert property (s_int_go |-> intrusion_input_oe_q[*8])
      else $error("intrusion pulse too short");
   a_int_len: assert property ($fell(intrusion_input_oe_q)
      |-> hi_int_q == PULSE_CYCLES) else $error("intrusion pulse length");
   a_int_on_write: assert property (s_int_go |-> scl_in)
      else $error("intrusion pulse without write");
   a_rst_min_len: assert property (s_rst_go
      |-> reset_or_overtemp_pin_oe_q[*8]) else $error("reset too short");
   a_rst_len: assert property ($fell(reset_or_overtemp_pin_oe_q)
      |-> hi_rst_q == PULSE_CYCLES) else $error("reset pulse length");
endmodule // monitor_config_register_bank_asserts
bind monitor_config_register_bank monitor_config_register_bank_asserts
   #(.PULSE_CYCLES(PULSE_CYCLES)) chk_inst (.clk_sys, .rst, .scl_in,
   .sda_oe_q, .monitor_run_q, .alert_oe_q, .reset_or_overtemp_pin_oe_q,
   .intrusion_input_oe_q, .general_output_pin_oe_q, .ot_cfg_q);

// ---- test/i2c_host_model.sv ----
`timescale 1ns/1ps
`include "monitor_consts.vh"
module i2c_host_model (
   input  wire  clk_sys, // Pacing clock.
   output logic scl,     // Serial clock.
   output logic sda_oe,  // Pulls data low.
   input  wire  sda      // Data line.
);
   // A quarter of the 64 ns serial clock period.
   localparam int Q = 16;
   int naks = 0;
   initial begin
      scl = 1'b1;
      sda_oe = 1'b0;
   end
   // Data only moves with the clock low, so no false start or stop.
   task automatic bit_io(input logic b, output logic r);
      #Q sda_oe = ~b;
      #Q scl = 1'b1;
      #(2*Q) r = sda;
      scl = 1'b0;
   endtask
   task automatic start();
      #Q sda_oe = 1'b0;
      #Q scl = 1'b1;
      #Q sda_oe = 1'b1;
      #Q scl = 1'b0;
   endtask
   task automatic stop();
      #Q sda_oe = 1'b1;
      #Q scl = 1'b1;
      #Q sda_oe = 1'b0;
      #Q;
   endtask
   task automatic xfer(input logic [7:0] d, input logic m,
                       output logic [7:0] q, output logic k);
      for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
      bit_io(m, k);
   endtask
   task automatic send(input logic [7:0] d);
      logic [7:0] q;
      logic       k;
      xfer(d, 1'b1, q, k);
      naks += int'(k);
   endtask
   task automatic reg_wr(input logic [7:0] a, v);
      @(negedge clk_sys);
      start();
      send({`DEV_ADDR, 1'b0});
      send(a);
      send(v);
      stop();
   endtask
   task automatic reg_rd(input logic [7:0] a, output logic [7:0] q);
      logic k;
      @(negedge clk_sys);
      start();
      send({`DEV_ADDR, 1'b0});
      send(a);
      start();
      send({`DEV_ADDR, 1'b1});
      xfer(8'hff, 1'b1, q, k);
      stop();
   endtask
endmodule // i2c_host_model

// ---- test/monitor_config_register_bank_tb.sv ----
`timescale 1ns/1ps
module monitor_config_register_bank_tb;
   localparam int P = 20;
   logic       clk_sys = 1'b0;
   logic       rst = 1'b1;
   logic [7:0] ev = 8'h00;
   logic       scl, h_oe, sda_oe, run, a_out, a_oe, r_oe, i_oe, g_oe;
   logic [7:0] ot_cfg;
   int         n_errors = 0, n_tests = 0, cyc = 0, r_hi = 0, i_hi = 0;
   logic [7:0] dflt [6] = '{8'h08, 8'h00, 8'h00, 8'h00, 8'h00, 8'h14};
   logic [23:0] rows [7] = '{24'h03a4a4, 24'h045a5a, 24'h01ff00,
      24'h060303, 24'h203300, 24'h058080, 24'h004141};
   // Open-drain data line with a pull-up: released reads high.
   wire        sda = ~(h_oe | sda_oe);
   always #2.5 clk_sys = ~clk_sys;
   monitor_config_register_bank #(.PULSE_CYCLES(P))
      monitor_config_register_bank_inst (.clk_sys, .rst, .scl_in(scl),
      .sda_in(sda), .sda_oe_q(sda_oe), .event_in_one(ev),
      .event_in_two(8'h00), .ot_alarm(1'b0), .monitor_run_q(run),
      .alert_out_q(a_out), .alert_oe_q(a_oe),
      .reset_or_overtemp_pin_oe_q(r_oe), .intrusion_input_oe_q(i_oe),
      .general_output_pin_oe_q(g_oe), .ot_cfg_q(ot_cfg));
   i2c_host_model i2c_host_model_inst (.clk_sys, .scl, .sda_oe(h_oe), .sda);
   task automatic print_verdict();
      $display("tests %0d errors %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic chk1(string n, logic e, logic g);
      n_tests++;
      if (g !== e) begin
         n_errors++;
         $display("BAD %s exp %b got %b", n, e, g);
      end
   endtask
   task automatic chk8(string n, logic [7:0] e, logic [7:0] g);
      n_tests++;
      if (g !== e) begin
         n_errors++;
         $display("BAD %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, v);
      i2c_host_model_inst.reg_wr(a, v);
   endtask
   task automatic rdc(input logic [7:0] a, e);
      logic [7:0] q;
      i2c_host_model_inst.reg_rd(a, q);
      chk8($sformatf("reg_%h", a), e, q);
   endtask
   task automatic event_pulse();
      ev = 8'h01;
      @(negedge clk_sys);
      ev = 8'h00;
      repeat (4) @(negedge clk_sys);
   endtask
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      r_hi <= r_hi + int'(r_oe);
      i_hi <= i_hi + int'(i_oe);
      if (cyc == 60000) begin
         n_errors++;
         print_verdict();
      end
   end
   initial begin
      repeat (4) @(negedge clk_sys);
      rst = 1'b0;
      repeat (4) @(negedge clk_sys);
      chk1("gpo_oe", 1'b1, g_oe);
      chk8("ot_cfg", 8'h01, ot_cfg);
      for (int i = 0; i < 6; i++) rdc(8'(i), dflt[i]);
      foreach (rows[i]) begin
         wr(rows[i][23:16], rows[i][15:8]);
         rdc(rows[i][23:16], rows[i][7:0]);
      end
      chk1("gpo_oe", 1'b0, g_oe);
      chk1("run", 1'b1, run);
      r_hi = 0;
      wr(8'h00, 8'h10);
      repeat (P + 10) @(negedge clk_sys);
      chk8("rst_hi", 8'(P), 8'(r_hi));
      rdc(8'h00, 8'h00);
      i_hi = 0;
      wr(8'h00, 8'h20);
      repeat (P + 10) @(negedge clk_sys);
      chk8("int_hi", 8'(P), 8'(i_hi));
      rdc(8'h00, 8'h00);
      wr(8'h00, 8'h03);
      event_pulse();
      chk1("alert_oe", 1'b1, a_oe);
      chk1("alert_lvl", 1'b0, a_out);
      wr(8'h00, 8'h0b);
      chk1("alert_oe", 1'b0, a_oe);
      chk1("run", 1'b0, run);
      wr(8'h00, 8'h03);
      chk1("alert_oe", 1'b1, a_oe);
      chk1("run", 1'b1, run);
      wr(8'h00, 8'h06);
      chk1("alert_oe", 1'b1, a_oe);
      chk1("alert_lvl", 1'b1, a_out);
      rdc(8'h01, 8'h01);
      rdc(8'h01, 8'h00);
      chk1("alert_oe", 1'b0, a_oe);
      event_pulse();
      wr(8'h00, 8'h04);
      chk1("alert_oe", 1'b0, a_oe);
      wr(8'h00, 8'h80);
      rdc(8'h00, 8'h08);
      rdc(8'h01, 8'h00);
      rdc(8'h03, 8'h00);
      rdc(8'h05, 8'h14);
      chk8("ot_cfg", 8'h01, ot_cfg);
      r_hi = 0;
      wr(8'h00, 8'h10);
      repeat (P + 10) @(negedge clk_sys);
      chk8("rst_hi", 8'h00, 8'(r_hi));
      rdc(8'h00, 8'h00);
      chk8("naks", 8'h00, 8'(i2c_host_model_inst.naks));
      print_verdict();
   end
endmodule // monitor_config_register_bank_tb
